// file: hdl/tlvi_arb_if.sv
// Interface carrying pending requests and the arbitration winner between controller and arbiter.
`timescale 1ns/100ps
`default_nettype none
interface tlvi_arb_if import tlvi_pkg::*; ();
  logic [NUM_ALL-1:0] pend;
  logic [NUM_SRC-1:0] en;
  logic [NUM_SRC-1:0] prio;
  logic gate;
  logic win_valid;
  tlvi_idx_t win_idx;
  tlvi_lvl_t win_lvl;
  modport arb (input pend, en, prio, gate, output win_valid, win_idx, win_lvl);
  modport ctl (output pend, en, prio, gate, input win_valid, win_idx, win_lvl);
endinterface
`default_nettype wire

// file: hdl/tlvi_arbiter.sv
// Combinational two-level arbiter with fixed natural order inside each level.
`timescale 1ns/100ps
`default_nettype none
module tlvi_arbiter import tlvi_pkg::*; (
  tlvi_arb_if.arb arb
);
  logic [NUM_SRC-1:0] act_hi;
  logic [NUM_SRC-1:0] act_lo;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_act
      assign act_hi[g] = arb.gate && arb.pend[g] && arb.en[g] && arb.prio[g];
      assign act_lo[g] = arb.gate && arb.pend[g] && arb.en[g] && !arb.prio[g];
    end
  endgenerate

  // Each later pass overrides the earlier, so the last match is the strongest.
  always_comb begin
    arb.win_valid = 1'b0;
    arb.win_idx = SRC_PG0;
    arb.win_lvl = LVL_NONE;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (act_lo[i]) begin
        arb.win_valid = 1'b1;
        arb.win_idx = tlvi_idx_t'(i);
        arb.win_lvl = LVL_LO;
      end
    end
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (act_hi[i]) begin
        arb.win_valid = 1'b1;
        arb.win_idx = tlvi_idx_t'(i);
        arb.win_lvl = LVL_HI;
      end
    end
    if (arb.gate && arb.pend[SRC_BKP]) begin
      arb.win_valid = 1'b1;
      arb.win_idx = SRC_BKP;
      arb.win_lvl = LVL_DBG;
    end
    if (arb.gate && arb.pend[SRC_DBG]) begin
      arb.win_valid = 1'b1;
      arb.win_idx = SRC_DBG;
      arb.win_lvl = LVL_DBG;
    end
  end
endmodule // tlvi_arbiter
`default_nettype wire

// file: hdl/tlvi_ctrl.sv
// Top of the two-level vectored interrupt controller with its Wishbone register file.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module tlvi_ctrl import tlvi_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [WB_DW-1:0] wb_dat_i,
  output logic [WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pin_group0_request_i,
  input wire logic pin_group1_request_i,
  input wire logic timer0_overflow_flag_i,
  input wire logic timer1_overflow_flag_i,
  input wire logic serial0_txrx_flags_i,
  input wire logic timer2_overflow_flag_i,
  input wire logic serial2_txrx_flags_i,
  input wire logic twowire_master_request_i,
  input wire logic low_voltage_request_i,
  input wire logic comparator_request_i,
  input wire logic converter_pwm_request_i,
  input wire logic watchdog_request_i,
  input wire logic counter_array_request_i,
  input wire logic serial_slaves_request_i,
  input wire logic clock_timer3_request_i,
  input wire logic breakpoint_request_i,
  input wire logic host_dbg_req_i,
  input wire logic [REG_W-1:0] host_dbg_id_i,
  input wire logic cpu_entry_i,
  input wire logic cpu_return_i,
  output logic irq_req_o,
  output logic [7:0] irq_vector_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // Request sampling.
  logic [1:0] pg_s;
  logic [3:0] evt_q;
  logic [3:0] evt_d;
  logic [9:0] lvl_q;
  logic [9:0] lvl_d;
  logic hreq_q;
  logic hreq_d;
  logic [REG_W-1:0] hid_q;
  logic [REG_W-1:0] hid_d;

  tlvi_sync #(.W(2)) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({pin_group1_request_i, pin_group0_request_i}),
    .q_o(pg_s)
  );

  always_comb begin
    evt_d = {breakpoint_request_i, twowire_master_request_i, timer1_overflow_flag_i, timer0_overflow_flag_i};
    lvl_d = {clock_timer3_request_i, serial_slaves_request_i, counter_array_request_i, watchdog_request_i,
             converter_pwm_request_i, comparator_request_i, low_voltage_request_i, serial2_txrx_flags_i,
             timer2_overflow_flag_i, serial0_txrx_flags_i};
    hreq_d = host_dbg_req_i;
    hid_d = host_dbg_id_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_q <= '0;
      lvl_q <= '0;
      hreq_q <= 1'b0;
      hid_q <= REG_RST;
    end else begin
      evt_q <= evt_d;
      lvl_q <= lvl_d;
      hreq_q <= hreq_d;
      hid_q <= hid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus. Registers are eight bits wide in byte lane 0; other lanes read zero.
  logic ack_q;
  logic ack_d;
  logic [REG_W-1:0] rdat_q;
  logic [REG_W-1:0] rdat_d;
  logic [REG_W-1:0] ie_q;
  logic [REG_W-1:0] ie_d;
  logic [REG_W-1:0] xen_q;
  logic [REG_W-1:0] xen_d;
  logic [PRI_W-1:0] pri_q;
  logic [PRI_W-1:0] pri_d;
  logic [REG_W-1:0] xpri_q;
  logic [REG_W-1:0] xpri_d;
  logic [2:0] dctl_q;
  logic [2:0] dctl_d;
  logic [REG_W-1:0] did_q;
  logic [REG_W-1:0] did_d;
  logic wr_acc;
  logic t0f_q;
  logic t1f_q;
  logic twmf_q;
  logic bkpf_q;
  logic dbgf_q;
  logic irq_req_q;
  tlvi_idx_t idx_q;
  tlvi_lvl_t lvl_sel_q;
  logic [2:0] ins_q;
  logic [7:0] vec_q;

  assign wr_acc = wb_cyc_i && wb_stb_i && !ack_q && wb_we_i && wb_sel_i[0];

  always_comb begin
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d = REG_RST;
    ie_d = ie_q;
    xen_d = xen_q;
    pri_d = pri_q;
    xpri_d = xpri_q;
    dctl_d = dctl_q;
    did_d = did_q;
    if (ack_d && !wb_we_i) begin
      case (wb_adr_i)
        ADR_IE: rdat_d = ie_q;
        ADR_XEN: rdat_d = xen_q;
        ADR_PRI: rdat_d = {1'b0, pri_q};
        ADR_XPRI: rdat_d = xpri_q;
        ADR_CFLAG: rdat_d = {4'h0, dbgf_q, bkpf_q, t1f_q, t0f_q};
        ADR_XFLAG: rdat_d = {lvl_q[LV_CT3:LV_PCA], 1'b0, lvl_q[LV_CONV:LV_LV], twmf_q};
        ADR_DBGCTL: rdat_d = {5'h00, dctl_q};
        ADR_DBGID: rdat_d = did_q;
        ADR_STAT: rdat_d = {ins_q, idx_q};
        default: rdat_d = REG_RST;
      endcase
    end
    if (wr_acc) begin
      case (wb_adr_i)
        ADR_IE: ie_d = wb_dat_i[REG_W-1:0];
        ADR_XEN: xen_d = wb_dat_i[REG_W-1:0];
        ADR_PRI: pri_d = wb_dat_i[PRI_W-1:0];
        ADR_XPRI: xpri_d = wb_dat_i[REG_W-1:0];
        ADR_DBGCTL: dctl_d = wb_dat_i[2:0];
        ADR_DBGID: did_d = wb_dat_i[REG_W-1:0];
        default: ie_d = ie_q;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= REG_RST;
      ie_q <= REG_RST;
      xen_q <= REG_RST;
      pri_q <= '0;
      xpri_q <= REG_RST;
      dctl_q <= '0;
      did_q <= REG_RST;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      ie_q <= ie_d;
      xen_q <= xen_d;
      pri_q <= pri_d;
      xpri_q <= xpri_d;
      dctl_q <= dctl_d;
      did_q <= did_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = {24'h000000, rdat_q};

  ////////////////////////////////////////////////////////////////////////////////
  // Flags held here. A write of 0 clears a bit, a write of 1 leaves it; a same-cycle event wins.
  logic t0f_d;
  logic t1f_d;
  logic twmf_d;
  logic bkpf_d;
  logic dbgf_d;
  logic take;
  logic dbg_hit;
  logic wr_cf;
  logic wr_xf;

  assign take = cpu_entry_i && irq_req_q;
  assign dbg_hit = hreq_q && dctl_q[DC_PORT] && (hid_q == did_q);
  assign wr_cf = wr_acc && (wb_adr_i == ADR_CFLAG);
  assign wr_xf = wr_acc && (wb_adr_i == ADR_XFLAG);

  always_comb begin
    t0f_d = evt_q[EV_T0] || (t0f_q && !(take && idx_q == SRC_T0) && !(wr_cf && !wb_dat_i[CF_T0]));
    t1f_d = evt_q[EV_T1] || (t1f_q && !(take && idx_q == SRC_T1) && !(wr_cf && !wb_dat_i[CF_T1]));
    twmf_d = evt_q[EV_TWM] || (twmf_q && !(wr_xf && !wb_dat_i[XF_TWM]));
    bkpf_d = evt_q[EV_BKP] || (bkpf_q && !(wr_cf && !wb_dat_i[CF_BKP]));
    dbgf_d = dbg_hit || (dbgf_q && !(wr_cf && !wb_dat_i[CF_DBG]));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t0f_q <= 1'b0;
      t1f_q <= 1'b0;
      twmf_q <= 1'b0;
      bkpf_q <= 1'b0;
      dbgf_q <= 1'b0;
    end else begin
      t0f_q <= t0f_d;
      t1f_q <= t1f_d;
      twmf_q <= twmf_d;
      bkpf_q <= bkpf_d;
      dbgf_q <= dbgf_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Arbitration and service tracking.
  tlvi_arb_if arb_if ();

  // Shared lines stay pending while any peripheral flag behind them is set.
  always_comb begin
    arb_if.pend[SRC_PG0] = pg_s[0];
    arb_if.pend[SRC_T0] = t0f_q;
    arb_if.pend[SRC_PG1] = pg_s[1];
    arb_if.pend[SRC_T1] = t1f_q;
    arb_if.pend[SRC_S0] = lvl_q[LV_S0];
    arb_if.pend[SRC_T2] = lvl_q[LV_T2];
    arb_if.pend[SRC_S2] = lvl_q[LV_S2];
    arb_if.pend[SRC_TWM] = twmf_q;
    arb_if.pend[SRC_CT3:SRC_LV] = lvl_q[LV_CT3:LV_LV];
    arb_if.pend[SRC_BKP] = bkpf_q && dctl_q[DC_BKP_EN];
    arb_if.pend[SRC_DBG] = dbgf_q && dctl_q[DC_DBG_EN];
    arb_if.en = {xen_q, ie_q[PRI_W-1:0]};
    arb_if.prio = {xpri_q, pri_q};
    arb_if.gate = ie_q[IE_GATE_BIT];
  end

  tlvi_arbiter u_arbiter (
    .arb(arb_if.arb)
  );

  logic irq_req_d;
  tlvi_idx_t idx_d;
  tlvi_lvl_t lvl_sel_d;
  logic [2:0] ins_d;
  logic [7:0] vec_d;

  always_comb begin
    ins_d = ins_q;
    if (cpu_return_i) begin
      case (top_level(ins_q))
        LVL_DBG: ins_d[INS_DBG] = 1'b0;
        LVL_HI: ins_d[INS_HI] = 1'b0;
        LVL_LO: ins_d[INS_LO] = 1'b0;
        default: ins_d = ins_q;
      endcase
    end
    if (take) begin
      case (lvl_sel_q)
        LVL_DBG: ins_d[INS_DBG] = 1'b1;
        LVL_HI: ins_d[INS_HI] = 1'b1;
        LVL_LO: ins_d[INS_LO] = 1'b1;
        default: ins_d[INS_LO] = ins_q[INS_LO];
      endcase
    end
    irq_req_d = arb_if.win_valid && (arb_if.win_lvl > top_level(ins_d));
    idx_d = arb_if.win_idx;
    lvl_sel_d = arb_if.win_lvl;
    vec_d = vec_of(arb_if.win_idx);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_q <= 1'b0;
      idx_q <= SRC_PG0;
      lvl_sel_q <= LVL_NONE;
      ins_q <= '0;
      vec_q <= VEC_BASE;
    end else begin
      irq_req_q <= irq_req_d;
      idx_q <= idx_d;
      lvl_sel_q <= lvl_sel_d;
      ins_q <= ins_d;
      vec_q <= vec_d;
    end
  end

  assign irq_req_o = irq_req_q;
  assign irq_vector_o = vec_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic hi_ready;
  assign hi_ready = ie_q[IE_GATE_BIT] && |(arb_if.pend[NUM_SRC-1:0] & arb_if.en & arb_if.prio);

  sequence dbg_match_s;
    hreq_q && dctl_q[DC_PORT] && hid_q == did_q;
  endsequence

  gate_off_a: assert property (!ie_q[IE_GATE_BIT] |=> !irq_req_o)
    else $error("Request raised while the global gate is closed.");
  t0_hwclear_a: assert property (take && idx_q == SRC_T0 && !evt_q[EV_T0] |=> !t0f_q)
    else $error("Timer 0 flag not cleared on routine entry.");
  sw_noset_a: assert property ($rose(twmf_q) |-> $past(evt_q[EV_TWM]))
    else $error("Two-wire master flag set without an event.");
  dbg_raise_a: assert property (dbg_match_s |=> dbgf_q)
    else $error("Matching host debug request did not raise the debug flag.");
  dbg_over_bkp_a: assert property (irq_req_o && idx_q == SRC_BKP |-> !$past(arb_if.pend[SRC_DBG]))
    else $error("Breakpoint chosen while debug was pending.");
  hi_first_a: assert property (hi_ready && top_level(ins_q) < LVL_HI && !cpu_entry_i && !cpu_return_i
    |=> irq_req_o && lvl_sel_q != LVL_LO)
    else $error("Low level request chosen over a ready high level request.");
  no_preempt_a: assert property (irq_req_o |-> lvl_sel_q > top_level(ins_q))
    else $error("Request does not outrank the routine in service.");
  vector_map_a: assert property (irq_req_o && idx_q == SRC_CT3 |-> irq_vector_o == VEC_CT3)
    else $error("Clock and timer 3 source carries the wrong vector.");
  pg0_order_a: assert property (irq_req_o && idx_q == SRC_PG0 |-> irq_vector_o == VEC_PG0 ##0
    !$past(arb_if.pend[SRC_DBG]))
    else $error("Pin group 0 vector wrong or chosen over debug.");
  mirror_a: assert property (ack_d && !wb_we_i && wb_adr_i == ADR_XFLAG |=> wb_dat_o[7] == $past(lvl_q[LV_CT3]))
    else $error("Mirrored flag read does not follow the peripheral line.");
endmodule // tlvi_ctrl
`default_nettype wire

// file: hdl/tlvi_pkg.sv
// Constants, types and helper functions shared by the two-level vectored interrupt controller.
// Contract
// - Fifteen peripheral sources, each assignable by software to low or high level.
// - Every request line is sampled on the rising system clock edge.
// - Pending enabled requests vector the CPU to the highest-priority routine.
// - Sources: seven core peripherals, six on-chip peripherals, two pin groups.
// - Vectors eight bytes apart: pin group 0 lowest, debug highest.
// - Timer 0 and Timer 1 flags clear on entry; others wait for software.
// - Software writes may only clear flags, never set them.
// - Same level ties resolved by fixed natural order, pin group 0 first.
// - High level requests always win over low level requests.
// - Debug and breakpoint rank above all fifteen peripheral sources.
// - Debug request raised when debug port configured and host identifier matches.
// - Breakpoint match raises breakpoint request; debug beats breakpoint.
// - Each source has its own enable bit in the enable registers.
// - Global gate bit 7 cleared blocks every interrupt.
// - Enable bits 6..0: serial2, timer2, serial0, timer1, pin1, timer0, pin0.
// - Set priority bit means high level, cleared means low level.
// - On-chip line flags mirror their peripheral flags; writes have no effect.
// - A mirror still set after return causes the routine to be entered again.
package tlvi_pkg;
  localparam int NUM_SRC = 15;
  localparam int NUM_ALL = 17;
  localparam int IDX_W = 5;
  localparam int ADR_W = 8;
  localparam int WB_DW = 32;
  localparam int REG_W = 8;
  localparam int PRI_W = 7;

  typedef logic [IDX_W-1:0] tlvi_idx_t;
  typedef enum logic [1:0] {
    LVL_NONE = 2'b00,
    LVL_LO = 2'b01,
    LVL_HI = 2'b10,
    LVL_DBG = 2'b11
  } tlvi_lvl_t;

  // Source index equals natural order minus one.
  localparam tlvi_idx_t SRC_PG0 = 5'h00;
  localparam tlvi_idx_t SRC_T0 = 5'h01;
  localparam tlvi_idx_t SRC_PG1 = 5'h02;
  localparam tlvi_idx_t SRC_T1 = 5'h03;
  localparam tlvi_idx_t SRC_S0 = 5'h04;
  localparam tlvi_idx_t SRC_T2 = 5'h05;
  localparam tlvi_idx_t SRC_S2 = 5'h06;
  localparam tlvi_idx_t SRC_TWM = 5'h07;
  localparam tlvi_idx_t SRC_LV = 5'h08;
  localparam tlvi_idx_t SRC_CT3 = 5'h0E;
  localparam tlvi_idx_t SRC_BKP = 5'h0F;
  localparam tlvi_idx_t SRC_DBG = 5'h10;

  localparam logic [7:0] VEC_BASE = 8'h03;
  localparam logic [7:0] VEC_STEP = 8'h08;
  localparam logic [7:0] VEC_PG0 = 8'h03;
  localparam logic [7:0] VEC_CT3 = 8'h73;
  localparam logic [7:0] VEC_DBG = 8'h83;

  localparam logic [ADR_W-1:0] ADR_CFLAG = 8'h88;
  localparam logic [ADR_W-1:0] ADR_XFLAG = 8'h90;
  localparam logic [ADR_W-1:0] ADR_IE = 8'hA8;
  localparam logic [ADR_W-1:0] ADR_PRI = 8'hB8;
  localparam logic [ADR_W-1:0] ADR_DBGCTL = 8'hC0;
  localparam logic [ADR_W-1:0] ADR_DBGID = 8'hC4;
  localparam logic [ADR_W-1:0] ADR_STAT = 8'hC8;
  localparam logic [ADR_W-1:0] ADR_XEN = 8'hE8;
  localparam logic [ADR_W-1:0] ADR_XPRI = 8'hF8;
  localparam logic [REG_W-1:0] REG_RST = 8'h00;

  localparam int IE_GATE_BIT = 7;
  localparam int CF_T0 = 0;
  localparam int CF_T1 = 1;
  localparam int CF_BKP = 2;
  localparam int CF_DBG = 3;
  localparam int XF_TWM = 0;
  localparam int DC_PORT = 0;
  localparam int DC_DBG_EN = 1;
  localparam int DC_BKP_EN = 2;
  localparam int INS_LO = 0;
  localparam int INS_HI = 1;
  localparam int INS_DBG = 2;

  // Bits of the sampled event pulses and sampled level lines.
  localparam int EV_T0 = 0;
  localparam int EV_T1 = 1;
  localparam int EV_TWM = 2;
  localparam int EV_BKP = 3;
  localparam int LV_S0 = 0;
  localparam int LV_T2 = 1;
  localparam int LV_S2 = 2;
  localparam int LV_LV = 3;
  localparam int LV_CMP = 4;
  localparam int LV_CONV = 5;
  localparam int LV_WD = 6;
  localparam int LV_PCA = 7;
  localparam int LV_SS = 8;
  localparam int LV_CT3 = 9;

  function automatic logic [7:0] vec_of(input tlvi_idx_t idx);
    vec_of = VEC_BASE + 8'(idx) * VEC_STEP;
  endfunction

  function automatic tlvi_lvl_t top_level(input logic [2:0] ins);
    if (ins[INS_DBG]) begin
      top_level = LVL_DBG;
    end else if (ins[INS_HI]) begin
      top_level = LVL_HI;
    end else if (ins[INS_LO]) begin
      top_level = LVL_LO;
    end else begin
      top_level = LVL_NONE;
    end
  endfunction
endpackage

// file: hdl/tlvi_sync.sv
// Two-stage synchroniser for request lines that arrive from pins.
`timescale 1ns/100ps
`default_nettype none
module tlvi_sync #(
  parameter int W = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;

  sample_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i, 2) |-> q_o == $past(d_i, 2))
    else $error("Synchronised line does not follow the input two edges later.");
endmodule // tlvi_sync
`default_nettype wire

// file: verification/tb.sv
// Self-checking testbench of the two-level vectored interrupt controller.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import tlvi_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic arm = 1'b0;
  logic ret = 1'b0;
  logic hreq = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [7:0] hid = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0] ev = 4'h0;
  logic [3:0] lag = 4'h0;
  logic [3:0] sel = 4'hF;
  logic [9:0] lv = 10'h000;
  logic [1:0] pg = 2'b00;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic ent;
  logic [7:0] vec;
  logic [31:0] lfsr_q = 32'hFA2E7D71;
  logic [9:0] m;
  int num_errors = 0;
  int n_checks = 0;
  int cyc_n = 0;
  int k;
  logic [7:0] exp_rd[$];
  logic [7:0] exp_vec[$];
  int idx_of[10] = '{4, 5, 6, 8, 9, 10, 11, 12, 13, 14};

  tlvi_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pin_group0_request_i(pg[0]), .pin_group1_request_i(pg[1]), .timer0_overflow_flag_i(ev[EV_T0]),
    .timer1_overflow_flag_i(ev[EV_T1]), .serial0_txrx_flags_i(lv[LV_S0]), .timer2_overflow_flag_i(lv[LV_T2]),
    .serial2_txrx_flags_i(lv[LV_S2]), .twowire_master_request_i(ev[EV_TWM]), .low_voltage_request_i(lv[LV_LV]),
    .comparator_request_i(lv[LV_CMP]), .converter_pwm_request_i(lv[LV_CONV]), .watchdog_request_i(lv[LV_WD]),
    .counter_array_request_i(lv[LV_PCA]), .serial_slaves_request_i(lv[LV_SS]),
    .clock_timer3_request_i(lv[LV_CT3]), .breakpoint_request_i(ev[EV_BKP]), .host_dbg_req_i(hreq),
    .host_dbg_id_i(hid), .cpu_entry_i(ent), .cpu_return_i(ret), .irq_req_o(irq), .irq_vector_o(vec));
  tlvi_cpu_model cpu_u (.clk_i(clk_i), .rst_i(rst_i), .irq_req_i(irq), .arm_i(arm), .lag_i(lag), .entry_o(ent));

  initial forever #2.5 clk_i = ~clk_i;

  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_i);
    end
    if (n == 50) cmp("bus ack", 8'h01, 8'h00);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    wb(1'b0, a, 8'h00);
  endtask
  task automatic entr(input logic [7:0] e);
    int n;
    n = 0;
    exp_vec.push_back(e);
    arm <= 1'b1;
    @(posedge clk_i);
    arm <= 1'b0;
    while (ent !== 1'b1 && n < 60) begin
      n++;
      @(posedge clk_i);
    end
    if (n == 60) cmp("entry", e, 8'h00);
    @(posedge clk_i);
  endtask
  task automatic quiet();
    repeat (6) @(posedge clk_i);
    cmp("irq_req", 8'h00, {7'h0, irq});
  endtask
  // Waits first so that cleared lines have left the sampling and sync stages.
  task automatic retn();
    repeat (5) @(posedge clk_i);
    ret <= 1'b1;
    @(posedge clk_i);
    ret <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge clk_i);
    ev[b] <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && exp_rd.size() > 0) cmp("read data", exp_rd.pop_front(), rdat[7:0]);
    if (ent === 1'b1) begin
      if (exp_vec.size() > 0) cmp("vector", exp_vec.pop_front(), vec);
      else cmp("unexpected entry", 8'h00, 8'h01);
    end
    cyc_n++;
    if (cyc_n == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADR_IE, REG_RST);
    wb(1'b1, ADR_PRI, 8'hFF);
    rd(ADR_PRI, 8'h7F);
    wb(1'b1, ADR_PRI, 8'h00);
    rd(8'h00, 8'h00);
    // A write without byte lane 0 must leave the register alone.
    sel <= 4'hE;
    wb(1'b1, ADR_PRI, 8'h55);
    sel <= 4'hF;
    rd(ADR_PRI, 8'h00);
    $display("test registers done");
    wb(1'b1, ADR_IE, 8'h0A);
    pulse(EV_T0);
    pulse(EV_T1);
    quiet();
    rd(ADR_CFLAG, 8'h03);
    wb(1'b1, ADR_CFLAG, 8'hFF);
    rd(ADR_CFLAG, 8'h03);
    wb(1'b1, ADR_CFLAG, 8'h01);
    rd(ADR_CFLAG, 8'h01);
    wb(1'b1, ADR_IE, 8'h82);
    entr(8'h0B);
    rd(ADR_CFLAG, 8'h00);
    retn();
    // The two-wire master flag survives routine entry and only a written 0 clears it.
    wb(1'b1, ADR_XEN, 8'h01);
    pulse(EV_TWM);
    entr(8'h3B);
    rd(ADR_XFLAG, 8'h01);
    wb(1'b1, ADR_XFLAG, 8'hFF);
    rd(ADR_XFLAG, 8'h01);
    wb(1'b1, ADR_XFLAG, 8'h00);
    rd(ADR_XFLAG, 8'h00);
    retn();
    $display("test flags done");
    wb(1'b1, ADR_IE, 8'hF0);
    wb(1'b1, ADR_XEN, 8'hFE);
    for (int i = 0; i < 8; i++) begin
      lfsr_q = nxt(lfsr_q);
      m = lfsr_q[9:0] | 10'h200;
      lag <= {2'b00, lfsr_q[13:12]};
      lv <= m;
      repeat (3) @(posedge clk_i);
      rd(ADR_XFLAG, {m[9], m[8], m[7], 1'b0, m[5], m[4], m[3], 1'b0});
      for (int j = 9; j >= 0; j--) if (m[j]) k = j;
      entr(8'h03 + 8'(idx_of[k]) * 8'h08);
      lv <= 10'h000;
      retn();
    end
    lv[LV_CMP] <= 1'b1;
    repeat (3) @(posedge clk_i);
    wb(1'b1, ADR_XFLAG, 8'h00);
    rd(ADR_XFLAG, 8'h04);
    $display("test natural order done");
    wb(1'b1, ADR_XPRI, 8'h10);
    entr(8'h4B);
    lv[LV_WD] <= 1'b1;
    entr(8'h5B);
    lv[LV_CONV] <= 1'b1;
    quiet();
    lv <= 10'h000;
    retn();
    retn();
    lv[LV_CMP] <= 1'b1;
    lv[LV_WD] <= 1'b1;
    entr(8'h5B);
    lv <= 10'h000;
    retn();
    lv[LV_CT3] <= 1'b1;
    entr(8'h73);
    retn();
    entr(8'h73);
    lv <= 10'h000;
    retn();
    $display("test levels done");
    wb(1'b1, ADR_IE, 8'h85);
    pg <= 2'b11;
    entr(8'h03);
    pg <= 2'b00;
    retn();
    pg <= 2'b10;
    entr(8'h13);
    pg <= 2'b00;
    retn();
    $display("test pins done");
    wb(1'b1, ADR_IE, 8'h80);
    wb(1'b1, ADR_DBGCTL, 8'h07);
    wb(1'b1, ADR_DBGID, 8'h5A);
    lv[LV_WD] <= 1'b1;
    hid <= 8'h33;
    hreq <= 1'b1;
    @(posedge clk_i);
    hreq <= 1'b0;
    entr(8'h5B);
    hid <= 8'h5A;
    hreq <= 1'b1;
    ev[EV_BKP] <= 1'b1;
    @(posedge clk_i);
    hreq <= 1'b0;
    ev[EV_BKP] <= 1'b0;
    entr(8'h83);
    wb(1'b1, ADR_CFLAG, 8'hF7);
    retn();
    entr(8'h7B);
    wb(1'b1, ADR_CFLAG, 8'h00);
    retn();
    lv <= 10'h000;
    retn();
    rd(ADR_CFLAG, 8'h00);
    $display("test debug done");
    complete_run();
  end
endmodule // tb
`default_nettype wire

// file: verification/tlvi_cpu_model.sv
// Behavioural model of the CPU sequencer that enters service routines on request.
`timescale 1ns/100ps
`default_nettype none
module tlvi_cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic irq_req_i,
  input wire logic arm_i,
  input wire logic [3:0] lag_i,
  output logic entry_o
);
  logic armed_q;
  logic [3:0] cnt_q;
  // One entry per arm, so a request still high at the entry edge is never taken twice.
  // A non-zero lag models a slow sequencer that finishes its current instruction first.
  always_ff @(posedge clk_i) begin
    entry_o <= 1'b0;
    if (rst_i) begin
      armed_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (arm_i) begin
      armed_q <= 1'b1;
      cnt_q <= 4'h0;
    end else if (armed_q && irq_req_i) begin
      if (cnt_q == lag_i) begin
        entry_o <= 1'b1;
        armed_q <= 1'b0;
      end
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // tlvi_cpu_model
`default_nettype wire
